// [iopr_defines.vh]
`ifndef IOPR_DEFINES_VH
`define IOPR_DEFINES_VH

// Port count, port width and flattened width of all pins.
`define IOPR_NPORT 5
`define IOPR_W 8
`define IOPR_ALLW 40

// Port indices.
`define IOPR_PA 3'h0
`define IOPR_PB 3'h1
`define IOPR_PC 3'h2
`define IOPR_PD 3'h3
`define IOPR_PE 3'h4

// Register kinds inside one port.
`define IOPR_K_DIN 3'h0
`define IOPR_K_CTRL 3'h1
`define IOPR_K_DOUT 3'h2
`define IOPR_K_DIR 3'h3
`define IOPR_K_ODR 3'h4
`define IOPR_K_LOGIC 3'h5
`define IOPR_K_CELL 3'h6

// Register offsets of the 8-bit map.
`define IOPR_OFF_A_DIN 8'h00
`define IOPR_OFF_B_DIN 8'h01
`define IOPR_OFF_A_CTRL 8'h02
`define IOPR_OFF_B_CTRL 8'h03
`define IOPR_OFF_A_DOUT 8'h04
`define IOPR_OFF_B_DOUT 8'h05
`define IOPR_OFF_A_DIR 8'h06
`define IOPR_OFF_B_DIR 8'h07
`define IOPR_OFF_A_LOGIC 8'h0a
`define IOPR_OFF_B_LOGIC 8'h0b
`define IOPR_OFF_A_CELL 8'h0c
`define IOPR_OFF_B_CELL 8'h0d
`define IOPR_OFF_C_DIN 8'h10
`define IOPR_OFF_D_DIN 8'h11
`define IOPR_OFF_C_CTRL 8'h12
`define IOPR_OFF_D_CTRL 8'h13
`define IOPR_OFF_C_DOUT 8'h14
`define IOPR_OFF_D_DOUT 8'h15
`define IOPR_OFF_C_DIR 8'h16
`define IOPR_OFF_D_DIR 8'h17
`define IOPR_OFF_C_ODR 8'h18
`define IOPR_OFF_D_ODR 8'h19
`define IOPR_OFF_E_DIN 8'h20
`define IOPR_OFF_E_CTRL 8'h22
`define IOPR_OFF_E_DOUT 8'h24
`define IOPR_OFF_E_DIR 8'h26
`define IOPR_OFF_E_LOGIC 8'h2a
`define IOPR_OFF_E_CELL 8'h2c

// Offsets at or above this hold port E; below it A/B and C/D pair up.
`define IOPR_OFF_SWAP_LIMIT 8'h20
`define IOPR_OFF_NONE 8'hff

// Reset values.
`define IOPR_CTRL_RST 8'h00
`define IOPR_DIR_RST 8'h00
`define IOPR_DOUT_RST 8'h00
`define IOPR_ODR_RST 8'h00
`define IOPR_BYTE_ZERO 8'h00

// Pin of port E that may carry the power-down counter clock.
`define IOPR_PE_CLK_PIN 7

`endif

// [iopr_port_bank.v]
`timescale 1ns/1ps
`include "iopr_defines.vh"

module iopr_port_bank #(
  parameter HAS_PORT_E_CELLS = 1
) (
  clk_sys,
  reset_n,
  clkEn,
  ioBlockChipSelect,
  busOffset,
  busWrite,
  busRead,
  busWrData,
  busWide16,
  busRdData,
  addrLatchStrobe,
  hostAddrLow,
  peripheralIoEnable,
  periphBusy,
  periphWrite,
  periphWrData,
  logicPinStatusA,
  logicPinStatusB,
  logicPinStatusE,
  cellOutA,
  cellOutB,
  cellOutE,
  cellOeA,
  cellOeB,
  cellOeE,
  altFuncSelE,
  pinInA,
  pinInB,
  pinInC,
  pinInD,
  pinInE,
  pinOutA,
  pinOutB,
  pinOutC,
  pinOutD,
  pinOutE,
  pinOeA,
  pinOeB,
  pinOeC,
  pinOeD,
  pinOeE,
  addrInLatchedA,
  addrInDirect,
  powerDownCounterClock
);
  input wire clk_sys;
  input wire reset_n;
  input wire clkEn;
  input wire ioBlockChipSelect;
  input wire [7:0] busOffset;
  input wire busWrite;
  input wire busRead;
  input wire [7:0] busWrData;
  input wire busWide16;
  output wire [7:0] busRdData;
  input wire addrLatchStrobe;
  input wire [7:0] hostAddrLow;
  input wire peripheralIoEnable;
  input wire periphBusy;
  input wire periphWrite;
  input wire [7:0] periphWrData;
  input wire [7:0] logicPinStatusA;
  input wire [7:0] logicPinStatusB;
  input wire [7:0] logicPinStatusE;
  input wire [7:0] cellOutA;
  input wire [7:0] cellOutB;
  input wire [7:0] cellOutE;
  input wire [7:0] cellOeA;
  input wire [7:0] cellOeB;
  input wire [7:0] cellOeE;
  input wire [7:0] altFuncSelE;
  input wire [7:0] pinInA;
  input wire [7:0] pinInB;
  input wire [7:0] pinInC;
  input wire [7:0] pinInD;
  input wire [7:0] pinInE;
  output wire [7:0] pinOutA;
  output wire [7:0] pinOutB;
  output wire [7:0] pinOutC;
  output wire [7:0] pinOutD;
  output wire [7:0] pinOutE;
  output wire [7:0] pinOeA;
  output wire [7:0] pinOeB;
  output wire [7:0] pinOeC;
  output wire [7:0] pinOeD;
  output wire [7:0] pinOeE;
  output wire [7:0] addrInLatchedA;
  output wire [23:0] addrInDirect;
  output wire powerDownCounterClock;

  // Folds a 16-bit-mode offset onto the 8-bit map.
  function [7:0] foldOffset;
    input [7:0] off;
    input wide;
    begin
      if (!wide) begin
        foldOffset = off;
      end else if (off < `IOPR_OFF_SWAP_LIMIT) begin
        foldOffset = {off[7:1], ~off[0]};
      end else if (off[0]) begin
        foldOffset = {off[7:1], 1'b0};
      end else begin
        foldOffset = `IOPR_OFF_NONE;
      end
    end
  endfunction

  // Decodes an 8-bit-map offset into {valid, port, kind}.
  function [6:0] decodeOffset;
    input [7:0] off;
    begin
      case (off)
        `IOPR_OFF_A_DIN: decodeOffset = {1'b1, `IOPR_PA, `IOPR_K_DIN};
        `IOPR_OFF_B_DIN: decodeOffset = {1'b1, `IOPR_PB, `IOPR_K_DIN};
        `IOPR_OFF_A_CTRL: decodeOffset = {1'b1, `IOPR_PA, `IOPR_K_CTRL};
        `IOPR_OFF_B_CTRL: decodeOffset = {1'b1, `IOPR_PB, `IOPR_K_CTRL};
        `IOPR_OFF_A_DOUT: decodeOffset = {1'b1, `IOPR_PA, `IOPR_K_DOUT};
        `IOPR_OFF_B_DOUT: decodeOffset = {1'b1, `IOPR_PB, `IOPR_K_DOUT};
        `IOPR_OFF_A_DIR: decodeOffset = {1'b1, `IOPR_PA, `IOPR_K_DIR};
        `IOPR_OFF_B_DIR: decodeOffset = {1'b1, `IOPR_PB, `IOPR_K_DIR};
        `IOPR_OFF_A_LOGIC: decodeOffset = {1'b1, `IOPR_PA, `IOPR_K_LOGIC};
        `IOPR_OFF_B_LOGIC: decodeOffset = {1'b1, `IOPR_PB, `IOPR_K_LOGIC};
        `IOPR_OFF_A_CELL: decodeOffset = {1'b1, `IOPR_PA, `IOPR_K_CELL};
        `IOPR_OFF_B_CELL: decodeOffset = {1'b1, `IOPR_PB, `IOPR_K_CELL};
        `IOPR_OFF_C_DIN: decodeOffset = {1'b1, `IOPR_PC, `IOPR_K_DIN};
        `IOPR_OFF_D_DIN: decodeOffset = {1'b1, `IOPR_PD, `IOPR_K_DIN};
        `IOPR_OFF_C_CTRL: decodeOffset = {1'b1, `IOPR_PC, `IOPR_K_CTRL};
        `IOPR_OFF_D_CTRL: decodeOffset = {1'b1, `IOPR_PD, `IOPR_K_CTRL};
        `IOPR_OFF_C_DOUT: decodeOffset = {1'b1, `IOPR_PC, `IOPR_K_DOUT};
        `IOPR_OFF_D_DOUT: decodeOffset = {1'b1, `IOPR_PD, `IOPR_K_DOUT};
        `IOPR_OFF_C_DIR: decodeOffset = {1'b1, `IOPR_PC, `IOPR_K_DIR};
        `IOPR_OFF_D_DIR: decodeOffset = {1'b1, `IOPR_PD, `IOPR_K_DIR};
        `IOPR_OFF_C_ODR: decodeOffset = {1'b1, `IOPR_PC, `IOPR_K_ODR};
        `IOPR_OFF_D_ODR: decodeOffset = {1'b1, `IOPR_PD, `IOPR_K_ODR};
        `IOPR_OFF_E_DIN: decodeOffset = {1'b1, `IOPR_PE, `IOPR_K_DIN};
        `IOPR_OFF_E_CTRL: decodeOffset = {1'b1, `IOPR_PE, `IOPR_K_CTRL};
        `IOPR_OFF_E_DOUT: decodeOffset = {1'b1, `IOPR_PE, `IOPR_K_DOUT};
        `IOPR_OFF_E_DIR: decodeOffset = {1'b1, `IOPR_PE, `IOPR_K_DIR};
        `IOPR_OFF_E_LOGIC: decodeOffset = {1'b1, `IOPR_PE, `IOPR_K_LOGIC};
        `IOPR_OFF_E_CELL: decodeOffset = {1'b1, `IOPR_PE, `IOPR_K_CELL};
        default: decodeOffset = {1'b0, `IOPR_PA, `IOPR_K_DIN};
      endcase
    end
  endfunction

  // Configuration and data state, flattened with port A in the low byte.
  reg [`IOPR_ALLW-1:0] ctrl_ff;
  reg [`IOPR_ALLW-1:0] dir_ff;
  reg [`IOPR_ALLW-1:0] dout_ff;
  reg [15:0] odr_ff;
  reg [7:0] addrLatch_ff;
  reg [7:0] addrInLatched_ff;
  reg [23:0] addrInDirect_ff;
  reg powerDownClk_ff;
  reg [7:0] busRdData_ff;
  reg [7:0] nxt_busRdData;
  reg [`IOPR_ALLW-1:0] pinOut_ff;
  reg [`IOPR_ALLW-1:0] pinOe_ff;

  wire [7:0] foldedOff;
  wire [6:0] decoded;
  wire hit;
  wire [2:0] selPort;
  wire [2:0] selKind;
  wire doWrite;
  wire [`IOPR_ALLW-1:0] pinIn;
  wire [`IOPR_ALLW-1:0] logicMask;
  wire [`IOPR_ALLW-1:0] cellOut;
  wire [`IOPR_ALLW-1:0] cellOe;
  wire [`IOPR_ALLW-1:0] nxt_pinOut;
  wire [`IOPR_ALLW-1:0] nxt_pinOe;
  wire [7:0] cellE;

  // Address decode inside the 256-byte chip-select window.
  assign foldedOff = foldOffset(busOffset, busWide16);
  assign decoded = decodeOffset(foldedOff);
  assign hit = ioBlockChipSelect & decoded[6];
  assign selPort = decoded[5:3];
  assign selKind = decoded[2:0];
  assign doWrite = clkEn & hit & busWrite;

  // Per-port inputs gathered into flat vectors; C and D carry no logic.
  assign pinIn = {pinInE, pinInD, pinInC, pinInB, pinInA};
  assign logicMask = {logicPinStatusE, `IOPR_BYTE_ZERO,
    `IOPR_BYTE_ZERO, logicPinStatusB, logicPinStatusA};
  assign cellOut = {cellOutE, `IOPR_BYTE_ZERO, `IOPR_BYTE_ZERO,
    cellOutB, cellOutA};
  assign cellOe = {cellOeE, `IOPR_BYTE_ZERO, `IOPR_BYTE_ZERO,
    cellOeB, cellOeA};

  // Port E cell readback exists only on the larger variant.
  assign cellE = HAS_PORT_E_CELLS ? cellOutE : `IOPR_BYTE_ZERO;

  // Register writes, one set of flops per port.
  genvar p;
  generate
    for (p = 0; p < `IOPR_NPORT; p = p + 1) begin : gPortRegs
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          ctrl_ff[p*8 +: 8] <= `IOPR_CTRL_RST;
          dir_ff[p*8 +: 8] <= `IOPR_DIR_RST;
          dout_ff[p*8 +: 8] <= `IOPR_DOUT_RST;
        end else if (doWrite && selPort == p) begin
          if (selKind == `IOPR_K_CTRL) begin
            ctrl_ff[p*8 +: 8] <= busWrData;
          end
          if (selKind == `IOPR_K_DIR) begin
            dir_ff[p*8 +: 8] <= busWrData;
          end
          if (selKind == `IOPR_K_DOUT) begin
            dout_ff[p*8 +: 8] <= busWrData;
          end
        end
      end
    end
  endgenerate

  // Open-drain selection exists only for ports C and D.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      odr_ff <= {`IOPR_ODR_RST, `IOPR_ODR_RST};
    end else if (doWrite && selKind == `IOPR_K_ODR) begin
      if (selPort == `IOPR_PC) begin
        odr_ff[7:0] <= busWrData;
      end
      if (selPort == `IOPR_PD) begin
        odr_ff[15:8] <= busWrData;
      end
    end
  end

  // Read multiplexer; unmapped offsets return zero.
  always @* begin
    nxt_busRdData = `IOPR_BYTE_ZERO;
    case (selKind)
      `IOPR_K_DIN: nxt_busRdData = pinIn[selPort*8 +: 8];
      `IOPR_K_CTRL: nxt_busRdData = ctrl_ff[selPort*8 +: 8];
      `IOPR_K_DOUT: nxt_busRdData = dout_ff[selPort*8 +: 8];
      `IOPR_K_DIR: nxt_busRdData = dir_ff[selPort*8 +: 8];
      `IOPR_K_ODR: begin
        if (selPort == `IOPR_PD) begin
          nxt_busRdData = odr_ff[15:8];
        end else begin
          nxt_busRdData = odr_ff[7:0];
        end
      end
      `IOPR_K_LOGIC: nxt_busRdData = logicMask[selPort*8 +: 8];
      `IOPR_K_CELL: begin
        if (selPort == `IOPR_PE) begin
          nxt_busRdData = cellE;
        end else begin
          nxt_busRdData = cellOut[selPort*8 +: 8];
        end
      end
      default: nxt_busRdData = `IOPR_BYTE_ZERO;
    endcase
  end

  // Read data is captured on a selected read strobe and held until the next selected read.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busRdData_ff <= `IOPR_BYTE_ZERO;
    end else if (clkEn && busRead && ioBlockChipSelect) begin
      busRdData_ff <= hit ? nxt_busRdData : `IOPR_BYTE_ZERO;
    end
  end

  // Address latch for address-out, and port A address-in capture.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addrLatch_ff <= `IOPR_BYTE_ZERO;
      addrInLatched_ff <= `IOPR_BYTE_ZERO;
    end else if (clkEn && addrLatchStrobe) begin
      addrLatch_ff <= hostAddrLow;
      addrInLatched_ff <= pinInA;
    end
  end

  // Ports B to D offer address inputs straight, never through the latch.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addrInDirect_ff <= {3{`IOPR_BYTE_ZERO}};
      powerDownClk_ff <= 1'b0;
    end else if (clkEn) begin
      addrInDirect_ff <= {pinInD, pinInC, pinInB};
      powerDownClk_ff <= altFuncSelE[`IOPR_PE_CLK_PIN] &
        pinInE[`IOPR_PE_CLK_PIN];
    end
  end

  // Output source and enable per pin for every port.
  generate
    for (p = 0; p < `IOPR_NPORT; p = p + 1) begin : gPinMux
      wire [7:0] lm;
      wire [7:0] ct;
      wire [7:0] dr;
      wire [7:0] muxOut;
      wire [7:0] stdOe;
      wire [7:0] addrOe;
      wire [7:0] baseOe;
      assign lm = logicMask[p*8 +: 8];
      assign ct = ctrl_ff[p*8 +: 8];
      assign dr = dir_ff[p*8 +: 8];
      // Three-way choice: logic cell, data-out or latched address.
      assign muxOut = (lm & cellOut[p*8 +: 8]) |
        (~lm & ct & dout_ff[p*8 +: 8]) |
        (~lm & ~ct & addrLatch_ff);
      assign stdOe = ~lm & ct & dr;
      assign addrOe = ~lm & ~ct & dr;
      assign baseOe = (lm & cellOe[p*8 +: 8]) | stdOe | addrOe;
      if (p == `IOPR_PA) begin : gPortA
        // Peripheral mode floats port A unless a write is under way.
        assign nxt_pinOut[7:0] = peripheralIoEnable ? periphWrData :
          muxOut;
        assign nxt_pinOe[7:0] = peripheralIoEnable ?
          {8{periphBusy & periphWrite}} : baseOe;
      end else if (p == `IOPR_PC || p == `IOPR_PD) begin : gPortCD
        // Open-drain pins only ever pull low.
        wire [7:0] od;
        assign od = odr_ff[(p - `IOPR_PC)*8 +: 8];
        assign nxt_pinOut[p*8 +: 8] = muxOut & ~od;
        assign nxt_pinOe[p*8 +: 8] = baseOe & ~(od & muxOut);
      end else if (p == `IOPR_PE) begin : gPortE
        // Alternate-function input pins never drive.
        assign nxt_pinOut[p*8 +: 8] = muxOut;
        assign nxt_pinOe[p*8 +: 8] = baseOe & ~altFuncSelE;
      end else begin : gPortB
        assign nxt_pinOut[p*8 +: 8] = muxOut;
        assign nxt_pinOe[p*8 +: 8] = baseOe;
      end
    end
  endgenerate

  // Pin drivers are registered so every pin output comes from a flop.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pinOut_ff <= {`IOPR_NPORT{`IOPR_BYTE_ZERO}};
      pinOe_ff <= {`IOPR_NPORT{`IOPR_BYTE_ZERO}};
    end else if (clkEn) begin
      pinOut_ff <= nxt_pinOut;
      pinOe_ff <= nxt_pinOe;
    end
  end

  // Output port wiring.
  assign busRdData = busRdData_ff;
  assign pinOutA = pinOut_ff[7:0];
  assign pinOutB = pinOut_ff[15:8];
  assign pinOutC = pinOut_ff[23:16];
  assign pinOutD = pinOut_ff[31:24];
  assign pinOutE = pinOut_ff[39:32];
  assign pinOeA = pinOe_ff[7:0];
  assign pinOeB = pinOe_ff[15:8];
  assign pinOeC = pinOe_ff[23:16];
  assign pinOeD = pinOe_ff[31:24];
  assign pinOeE = pinOe_ff[39:32];
  assign addrInLatchedA = addrInLatched_ff;
  assign addrInDirect = addrInDirect_ff;
  assign powerDownCounterClock = powerDownClk_ff;

endmodule // iopr_port_bank

// [iopr_port_bank_asserts.sv]
`timescale 1ns/1ps
// Pin and bus relations of the bank, watched from its ports only.
module iopr_port_bank_asserts (
  input wire clk_sys,
  input wire reset_n,
  input wire clkEn,
  input wire ioBlockChipSelect,
  input wire [7:0] busOffset,
  input wire busRead,
  input wire busWide16,
  input wire [7:0] busRdData,
  input wire addrLatchStrobe,
  input wire peripheralIoEnable,
  input wire periphBusy,
  input wire periphWrite,
  input wire [7:0] periphWrData,
  input wire [7:0] altFuncSelE,
  input wire [7:0] pinInA,
  input wire [7:0] pinInB,
  input wire [7:0] pinInC,
  input wire [7:0] pinInD,
  input wire [7:0] pinInE,
  input wire [7:0] pinOutA,
  input wire [7:0] pinOeA,
  input wire [7:0] pinOeE,
  input wire [7:0] addrInLatchedA,
  input wire [23:0] addrInDirect,
  input wire powerDownCounterClock
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  pd_clock_a:
    assert property (clkEn |=> powerDownCounterClock
      == $past(pinInE[7] & altFuncSelE[7])) else $error("pd clock wrong");
  alt_float_a:
    assert property (clkEn && altFuncSelE[7] |=> !pinOeE[7])
      else $error("alternate input pin drives");
  direct_addr_a:
    assert property (clkEn |=> addrInDirect
      == $past({pinInD, pinInC, pinInB})) else $error("direct address");
  latch_take_a:
    assert property (clkEn && addrLatchStrobe |=> addrInLatchedA
      == $past(pinInA)) else $error("address latch missed");
  latch_hold_a:
    assert property (clkEn && !addrLatchStrobe |=> $stable(addrInLatchedA))
      else $error("address latch moved");
  periph_idle_a:
    assert property (clkEn && peripheralIoEnable && !periphBusy
      |=> pinOeA == 8'h00) else $error("port A driven while idle");
  periph_write_a:
    assert property (clkEn && peripheralIoEnable && periphBusy && periphWrite
      |-> ##1 pinOeA == 8'hff && pinOutA == $past(periphWrData))
      else $error("peripheral write not driven");
  din_read_a:
    assert property (clkEn && ioBlockChipSelect && busRead && !busWide16
      && busOffset == 8'h00 |=> busRdData == $past(pinInA))
      else $error("data-in read wrong");
  cs_gate_a:
    assert property (clkEn && busRead && !ioBlockChipSelect
      |=> $stable(busRdData)) else $error("read without select");
endmodule // iopr_port_bank_asserts

bind iopr_port_bank iopr_port_bank_asserts iopr_port_bank_asserts_i (
  .clk_sys, .reset_n, .clkEn, .ioBlockChipSelect, .busOffset, .busRead,
  .busWide16, .busRdData, .addrLatchStrobe, .peripheralIoEnable,
  .periphBusy, .periphWrite, .periphWrData, .altFuncSelE, .pinInA,
  .pinInB, .pinInC, .pinInD, .pinInE, .pinOutA, .pinOeA, .pinOeE,
  .addrInLatchedA, .addrInDirect, .powerDownCounterClock
);

// [iopr_host_model.sv]
`timescale 1ns/1ps
// Host side of the register bus; it moves its lines on falling edges.
module iopr_host_model (
  input wire clk_sys,
  output reg ioBlockChipSelect = 1'b0,
  output reg [7:0] busOffset = 8'h00,
  output reg busWrite = 1'b0,
  output reg busRead = 1'b0,
  output reg [7:0] busWrData = 8'h00,
  input wire [7:0] busRdData
);
  // One transfer held across its taking edge; on release the strobes drop low and offset and data are inverted.
  task automatic cycle(input cs, input wr, input [7:0] off, input [7:0] dat);
    @(negedge clk_sys);
    {ioBlockChipSelect, busWrite, busRead} = {cs, wr, !wr};
    {busOffset, busWrData} = {off, dat};
    @(negedge clk_sys);
    {ioBlockChipSelect, busWrite, busRead} = 3'b000;
    {busOffset, busWrData} = ~{off, dat};
  endtask
endmodule // iopr_host_model

// [iopr_port_bank_bench.sv]
`timescale 1ns/1ps
// Drives the bank through its host and pins and compares the answers.
module iopr_port_bank_bench;
  reg clk_sys = 1'b0;
  reg reset_n = 1'b0;
  reg busWide16 = 1'b0, addrLatchStrobe = 1'b0, peripheralIoEnable = 1'b0;
  reg periphBusy = 1'b0, periphWrite = 1'b0, clkEn = 1'b1;
  reg [7:0] hostAddrLow = 8'h00, periphWrData = 8'h00, altFuncSelE = 8'h00;
  reg [7:0] logicPinStatusA = 8'h00, logicPinStatusB = 8'h00;
  reg [7:0] logicPinStatusE = 8'h00, cellOutA = 8'h00, cellOutB = 8'h00;
  reg [7:0] cellOutE = 8'h00, cellOeA = 8'h00, cellOeB = 8'h00;
  reg [7:0] cellOeE = 8'h00, pinInA = 8'h1a, pinInB = 8'h2b;
  reg [7:0] pinInC = 8'h3c, pinInD = 8'h4d, pinInE = 8'h5e;
  wire ioBlockChipSelect, busWrite, busRead, powerDownCounterClock;
  wire [7:0] busOffset, busWrData, busRdData, addrInLatchedA;
  wire [7:0] pinOutA, pinOutB, pinOutC, pinOutD, pinOutE;
  wire [7:0] pinOeA, pinOeB, pinOeC, pinOeD, pinOeE;
  wire [23:0] addrInDirect;
  int nFail = 0, checksDone = 0, cycles = 0, i;
  reg [7:0] offs [0:16] = '{8'h02, 8'h03, 8'h12, 8'h13, 8'h22, 8'h06,
    8'h07, 8'h16, 8'h17, 8'h26, 8'h04, 8'h05, 8'h14, 8'h15, 8'h24,
    8'h18, 8'h19};
  reg [7:0] roOffs [0:10] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h20, 8'h0a,
    8'h0b, 8'h2a, 8'h0c, 8'h0d, 8'h2c};
  reg [7:0] exps [0:10];

  // Design and host, every pin wired by name.
  iopr_port_bank iopr_port_bank_i (
    .clk_sys, .reset_n, .clkEn, .ioBlockChipSelect, .busOffset,
    .busWrite, .busRead, .busWrData, .busWide16, .busRdData,
    .addrLatchStrobe, .hostAddrLow, .peripheralIoEnable, .periphBusy,
    .periphWrite, .periphWrData, .logicPinStatusA, .logicPinStatusB,
    .logicPinStatusE, .cellOutA, .cellOutB, .cellOutE, .cellOeA, .cellOeB,
    .cellOeE, .altFuncSelE, .pinInA, .pinInB, .pinInC, .pinInD, .pinInE,
    .pinOutA, .pinOutB, .pinOutC, .pinOutD, .pinOutE, .pinOeA, .pinOeB,
    .pinOeC, .pinOeD, .pinOeE, .addrInLatchedA, .addrInDirect,
    .powerDownCounterClock
  );
  iopr_host_model iopr_host_model_i (
    .clk_sys, .ioBlockChipSelect, .busOffset, .busWrite, .busRead,
    .busWrData, .busRdData
  );

  // Free-running system clock.
  initial forever #5 clk_sys = ~clk_sys;

  task check(input string what, input [7:0] seen, input [7:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input [7:0] off, input [7:0] dat);
    iopr_host_model_i.cycle(1'b1, 1'b1, off, dat);
  endtask
  task rdChk(input [7:0] off, input [7:0] exp);
    iopr_host_model_i.cycle(1'b1, 1'b0, off, 8'h00);
    check($sformatf("register %h", off), busRdData, exp);
  endtask
  task settle;
    repeat (2) @(negedge clk_sys);
  endtask
  task endTest(input string name);
    $display("test %s finished", name);
  endtask
  task completeRun;
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nFail++;
      completeRun();
    end
  end

  // Main sequence of tests.
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) reset_n = 1'b1;
    for (i = 0; i < 10; i++) rdChk(offs[i], 8'h00);
    endTest("reset");
    for (i = 0; i < 17; i++) wr(offs[i], 8'(i * 8'h0b + 8'h03));
    for (i = 0; i < 17; i++)
      rdChk(offs[i], 8'(i * 8'h0b + 8'h03));
    endTest("readback");
    {logicPinStatusA, logicPinStatusB, logicPinStatusE} = 24'h616263;
    {cellOutA, cellOutB, cellOutE} = 24'h717273;
    exps = '{pinInA, pinInB, pinInC, pinInD, pinInE, 8'h61, 8'h62, 8'h63,
      8'h71, 8'h72, 8'h73};
    for (i = 0; i < 11; i++) wr(roOffs[i], ~exps[i]);
    for (i = 0; i < 11; i++) rdChk(roOffs[i], exps[i]);
    endTest("read only");
    busWide16 = 1'b1;
    rdChk(8'h00, pinInB);
    rdChk(8'h11, pinInC);
    rdChk(8'h21, pinInE);
    rdChk(8'h0b, 8'h61);
    rdChk(8'h2d, 8'h73);
    rdChk(8'h26, 8'h00);
    wr(8'h06, 8'h9c);
    busWide16 = 1'b0;
    rdChk(8'h07, 8'h9c);
    {logicPinStatusA, logicPinStatusB, logicPinStatusE} = 24'h000000;
    endTest("wide map");
    wr(8'h05, 8'h96);
    wr(8'h07, 8'hf0);
    wr(8'h03, 8'hff);
    settle;
    check("pinOeB", pinOeB, 8'hf0);
    check("pinOutB", pinOutB & 8'hf0, 8'h90);
    hostAddrLow = 8'h3c;
    addrLatchStrobe = 1'b1;
    @(negedge clk_sys) addrLatchStrobe = 1'b0;
    check("addrInLatchedA", addrInLatchedA, pinInA);
    wr(8'h02, 8'h00);
    wr(8'h06, 8'hff);
    settle;
    check("pinOutA", pinOutA, 8'h3c);
    check("pinOeA", pinOeA, 8'hff);
    wr(8'h04, 8'h5a);
    wr(8'h02, 8'hff);
    settle;
    check("pinOutA", pinOutA, 8'h5a);
    {logicPinStatusA, cellOeA, cellOutA} = 24'hff3355;
    settle;
    check("pinOeA", pinOeA, 8'h33);
    check("pinOutA", pinOutA & 8'h33, 8'h11);
    logicPinStatusA = 8'h00;
    wr(8'h06, 8'h00);
    settle;
    check("pinOeA", pinOeA, 8'h00);
    endTest("pin modes");
    wr(8'h18, 8'h00);
    wr(8'h14, 8'h0f);
    wr(8'h16, 8'hff);
    wr(8'h12, 8'hff);
    // Port D mixes push-pull and open-drain pins in one byte.
    wr(8'h19, 8'h0f);
    wr(8'h15, 8'h55);
    wr(8'h17, 8'hff);
    wr(8'h13, 8'hff);
    settle;
    check("pinOeC", pinOeC, 8'hff);
    check("pinOutC", pinOutC, 8'h0f);
    check("pinOeD", pinOeD, 8'hfa);
    check("pinOutD", pinOutD, 8'h50);
    wr(8'h18, 8'hff);
    settle;
    check("pinOeC", pinOeC, 8'hf0);
    check("pinOutC", pinOutC & 8'hf0, 8'h00);
    endTest("open drain");
    peripheralIoEnable = 1'b1;
    wr(8'h06, 8'hff);
    settle;
    check("pinOeA", pinOeA, 8'h00);
    {periphBusy, periphWrite, periphWrData} = 10'h3c3;
    settle;
    check("pinOeA", pinOeA, 8'hff);
    check("pinOutA", pinOutA, 8'hc3);
    {periphBusy, periphWrite, peripheralIoEnable} = 3'b000;
    endTest("peripheral");
    {pinInE, altFuncSelE, pinInB} = 24'h8080b4;
    wr(8'h26, 8'hff);
    wr(8'h22, 8'hff);
    settle;
    check("pdClock", {7'h00, powerDownCounterClock}, 8'h01);
    check("pinOeE", pinOeE, 8'h7f);
    check("pinOutE", pinOutE, 8'h9d);
    check("addrB", addrInDirect[7:0], 8'hb4);
    check("addrD", addrInDirect[23:16], pinInD);
    endTest("alternate");
    wr(8'h08, 8'hff);
    rdChk(8'h08, 8'h00);
    rdChk(8'h02, 8'hff);
    iopr_host_model_i.cycle(1'b0, 1'b1, 8'h02, 8'h00);
    iopr_host_model_i.cycle(1'b0, 1'b0, 8'h00, 8'h00);
    check("busRdData", busRdData, 8'hff);
    rdChk(8'h02, 8'hff);
    endTest("select");
    // With the enable low neither a write nor a pin sample may land.
    clkEn = 1'b0;
    pinInB = 8'h00;
    wr(8'h02, 8'h00);
    check("addrB", addrInDirect[7:0], 8'hb4);
    clkEn = 1'b1;
    rdChk(8'h02, 8'hff);
    endTest("enable");
    completeRun();
  end
endmodule // iopr_port_bank_bench
